// ### pkg/ldocrb_pkg.sv
/*
 * package for the upper regulator control register bank: offsets, field positions,
 * reset values and voltage-table constants.
 * assumes the serial control interface presents byte-wide register accesses.
 */
package ldocrb_pkg;
	localparam int NUM_REG = 6;
	localparam logic [7:0] OFS_REG5 = 8'h1C;
	localparam logic [7:0] OFS_REG6 = 8'h1D;
	localparam logic [7:0] OFS_REG7 = 8'h1E;
	localparam logic [7:0] OFS_REG8 = 8'h1F;
	localparam logic [7:0] OFS_REG9 = 8'h20;
	localparam logic [7:0] OFS_REG10 = 8'h21;
	localparam int BIT_ENABLE = 7;
	localparam int BIT_LOWPWR = 6;
	localparam int BIT_RANGE = 5;
	localparam logic RST_LOWPWR = 1'h0;
	localparam logic [5:0] SEL_UPPER_BASE = 6'h20;
	localparam logic [5:0] SEL_TOP_STEP = 6'h3C;
	localparam logic [11:0] MV_LOW_BASE = 12'h320;
	localparam logic [11:0] MV_LOW_STEP = 12'h019;
	localparam logic [11:0] MV_UP_BASE = 12'h640;
	localparam logic [11:0] MV_UP_STEP = 12'h032;
	localparam logic [11:0] MV_TOP_BASE = 12'hBB8;
	localparam logic [11:0] MV_TOP_STEP = 12'h064;
	typedef logic [7:0] ldocrb_byte_t;
endpackage

// ### core/ldocrb_vdecode.sv
/*
 * voltage-code decoder: maps an effective 6-bit code to millivolts.
 * assumes the caller has already forced the range bit for upper-only regulators.
 */
`timescale 1ns/1ps
module ldocrb_vdecode (
	input wire logic [5:0] sel_i,
	output logic [11:0] mv_o
);
	import ldocrb_pkg::*;

	always_comb begin
		if (sel_i[BIT_RANGE] == 1'b0) begin
			mv_o = MV_LOW_BASE + MV_LOW_STEP * {6'h00, sel_i};
		end else if (sel_i <= SEL_TOP_STEP) begin
			mv_o = MV_UP_BASE + MV_UP_STEP * {6'h00, sel_i - SEL_UPPER_BASE};
		end else begin
			mv_o = MV_TOP_BASE + MV_TOP_STEP * {6'h00, sel_i - SEL_TOP_STEP};
		end
	end
endmodule

// ### core/ldocrb_bank.sv
/*
 * regulator control register bank for regulators five through ten.
 * assumes the serial interface gives one-cycle read and write strobes with byte address,
 * and that the one-time-programmable defaults are stable at the first clock edge after reset is released.
 */
`timescale 1ns/1ps
module ldocrb_bank (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic [7:0] addr_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire ldocrb_pkg::ldocrb_byte_t wdata_i,
	input wire logic [47:0] otp_default_i,
	input wire logic [5:0] force_off_i,
	output ldocrb_pkg::ldocrb_byte_t rdata_o,
	output logic rvalid_o,
	output logic [5:0] enable_o,
	output logic [5:0] lowpwr_o,
	output logic [35:0] sel_o,
	output logic [11:0] mv_o,
	output logic [2:0] mv_idx_o
);
	import ldocrb_pkg::*;

	// index 0 is the fifth regulator, index 5 the tenth
	function automatic logic [2:0] reg_index(input logic [7:0] a);
		return 3'(a - OFS_REG5);
	endfunction

	function automatic logic hit(input logic [7:0] a);
		return (a >= OFS_REG5) && (a <= OFS_REG10);
	endfunction

	function automatic logic [5:0] eff_sel(input logic [2:0] idx, input logic [5:0] s);
		// the fifth regulator only has the upper range, so bit 5 never reaches the decoder as zero
		return (idx == 3'h0) ? (s | SEL_UPPER_BASE) : s;
	endfunction

	ldocrb_byte_t regs [NUM_REG];
	ldocrb_byte_t next_regs [NUM_REG];
	logic loaded;
	logic next_loaded;
	ldocrb_byte_t next_rdata;
	logic next_rvalid;
	logic [5:0] next_enable;
	logic [5:0] next_lowpwr;
	logic [35:0] next_sel;
	logic [2:0] scan;
	logic [2:0] next_scan;
	logic [11:0] next_mv;
	logic [11:0] dec_mv;

	ldocrb_vdecode ldocrb_vdecode_i (
		.sel_i(eff_sel(scan, regs[scan][5:0])),
		.mv_o(dec_mv)
	);

	always_comb begin
		next_loaded = 1'b1;
		for (int i = 0; i < NUM_REG; i++) begin
			next_regs[i] = regs[i];
			if (!loaded) begin
				// defaults are taken after reset release, never as async reset values
				next_regs[i] = otp_default_i[i*8 +: 8];
				next_regs[i][BIT_LOWPWR] = RST_LOWPWR;
			end
		end
		// writes to offsets outside the bank are ignored here; other blocks own them
		if (loaded && wr_i && hit(addr_i)) begin
			next_regs[reg_index(addr_i)] = wdata_i;
		end
		next_rvalid = rd_i;
		next_rdata = 8'h00;
		if (rd_i && hit(addr_i)) begin
			next_rdata = regs[reg_index(addr_i)];
		end
		for (int i = 0; i < NUM_REG; i++) begin
			next_enable[i] = next_regs[i][BIT_ENABLE] && !force_off_i[i];
			next_lowpwr[i] = next_regs[i][BIT_LOWPWR];
			next_sel[i*6 +: 6] = eff_sel(3'(i), next_regs[i][5:0]);
		end
		next_scan = (scan == 3'(NUM_REG - 1)) ? 3'h0 : 3'(scan + 3'h1);
		next_mv = dec_mv;
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			for (int i = 0; i < NUM_REG; i++) begin
				regs[i] <= 8'h00;
			end
			loaded <= 1'b0;
			rdata_o <= 8'h00;
			rvalid_o <= 1'b0;
			enable_o <= 6'h00;
			lowpwr_o <= 6'h00;
			sel_o <= 36'h0;
			scan <= 3'h0;
			mv_o <= 12'h000;
			mv_idx_o <= 3'h0;
		end else begin
			regs <= next_regs;
			loaded <= next_loaded;
			rdata_o <= next_rdata;
			rvalid_o <= next_rvalid;
			enable_o <= next_enable;
			lowpwr_o <= next_lowpwr;
			sel_o <= next_sel;
			scan <= next_scan;
			mv_o <= next_mv;
			mv_idx_o <= scan;
		end
	end
endmodule

// ### sim/ldocrb_bank_sva.sv
/* bank port checker; assumes a bind from the bench top */
`timescale 1ns/1ps
module ldocrb_bank_sva (
	input wire logic clk_i, arst_n_i, wr_i, rd_i, rvalid_o,
	input wire logic [7:0] addr_i, wdata_i, rdata_o,
	input wire logic [5:0] force_off_i, enable_o, lowpwr_o,
	input wire logic [35:0] sel_o,
	input wire logic [11:0] mv_o,
	input wire logic [2:0] mv_idx_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	a_read_valid: assert property (rd_i |=> rvalid_o) else $error("no rvalid");
	a_valid_only: assert property (!rd_i |=> !rvalid_o) else $error("stray rvalid");
	a_force_off: assert property (force_off_i[0] |=> !enable_o[0]) else $error("forced on");
	// first edge after release still shows reset zeros
	a_range_bit: assert property ($past(arst_n_i) |-> sel_o[5]) else $error("bit5 low");
	a_write_code: assert property (wr_i && addr_i == 8'h1E |=> sel_o[17:12] == $past(wdata_i[5:0]))
		else $error("code");
	a_write_lowpwr: assert property (wr_i && addr_i == 8'h1D |=> lowpwr_o[1] == $past(wdata_i[6]))
		else $error("lowpwr");
	a_rsvd_read: assert property (rd_i && addr_i == 8'h22 |=> rdata_o == 8'h00) else $error("rsvd");
	a_upper_volt: assert property ($past(arst_n_i) && mv_idx_o == 3'h0 |-> mv_o >= 12'h640)
		else $error("range");
	c_read: cover property (rd_i ##1 rvalid_o);
	c_write: cover property (wr_i);
	c_force: cover property (force_off_i[0]);
endmodule

// ### sim/tb_ldocrb_bank.sv
/* bench for the bank; drives the register strobes directly */
`timescale 1ns/1ps
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin num_errors++; \
	$display("unexpected %s exp %h got %h", n, e, a); end end
module tb_ldocrb_bank;
	import ldocrb_pkg::*;
	logic clk_i = 0, arst_n_i = 0, wr_i = 0, rd_i = 0, rvalid_o;
	logic [7:0] addr_i = 0, wdata_i = 0, rdata_o, d;
	logic [47:0] otp_default_i = 48'h7D_DF_00_A5_41_4A;
	logic [5:0] force_off_i = 0, enable_o, lowpwr_o;
	logic [35:0] sel_o;
	logic [11:0] mv_o;
	logic [2:0] mv_idx_o;
	int num_errors = 0, compares = 0;
	ldocrb_bank ldocrb_bank_i (.*);
	always #12.5 clk_i = ~clk_i;
	task automatic final_report;
		if (num_errors == 0 && compares > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// an idle edge after each access keeps strobes from toggling twice in one step
	task automatic wr(input logic [7:0] a, w);
		addr_i = a; wdata_i = w; wr_i = 1;
		@(posedge clk_i); #2 wr_i = 0;
		@(posedge clk_i); #2;
	endtask
	task automatic rd(input logic [7:0] a);
		addr_i = a; rd_i = 1;
		@(posedge clk_i); #2 rd_i = 0; d = rdata_o;
		`CHK("rvalid", 1'b1, rvalid_o)
		@(posedge clk_i); #2;
	endtask
	task automatic do_reset;
		arst_n_i = 0; repeat (5) @(posedge clk_i); #2 arst_n_i = 1;
		repeat (2) @(posedge clk_i); #2;
	endtask
	task automatic t_defaults;
		for (int i = 0; i < 6; i++) begin
			rd(OFS_REG5 + 8'(i));
			`CHK("reg", otp_default_i[i*8 +: 8] & 8'hBF, d)
		end
		`CHK("en", 6'h14, enable_o)
	endtask
	task automatic t_write;
		wr(OFS_REG6, 8'hFF); wr(OFS_REG5, 8'h05); wr(8'h22, 8'hFF); wr(OFS_REG7, 8'h0A);
		`CHK("sel7", 6'h0A, sel_o[17:12])
		`CHK("en7", 1'b0, enable_o[2])
		rd(OFS_REG6); `CHK("reg6", 8'hFF, d)
		rd(OFS_REG5); `CHK("reg5", 8'h05, d)
		`CHK("sel5", 6'h25, sel_o[5:0])
		`CHK("lp", 6'h02, lowpwr_o)
		rd(8'h22); `CHK("rsvd", 8'h00, d)
	endtask
	task automatic t_force;
		force_off_i = 6'h3F; repeat (2) @(posedge clk_i); #2;
		`CHK("forced", 6'h00, enable_o)
		force_off_i = 6'h00;
	endtask
	task automatic t_volt(input logic [2:0] i, input logic [11:0] mv);
		int n = 0;
		while (mv_idx_o !== i && n < 20) begin @(posedge clk_i); #2; n++; end
		if (n == 20) begin num_errors++; final_report; end
		`CHK("mv", mv, mv_o)
	endtask
	initial begin
		do_reset; t_defaults; t_write; t_force;
		t_volt(3'h0, 12'h73A); t_volt(3'h1, 12'hCE4);
		t_volt(3'h3, 12'h320); t_volt(3'h5, 12'hC1C);
		do_reset; t_defaults;
		final_report;
	end
endmodule
bind ldocrb_bank ldocrb_bank_sva ldocrb_bank_sva_i (.*);
